// [rtl/safe_standstill_interlock.sv]
// Per-drive safe standstill interlock with two-channel check and safe brake control.
//
// Summary of operation
// - Each drive keeps separate standstill enable and status.
// - Fault when the two channels disagree too long.
// - Source selector: inputs 0-7, extension only 0-3.
// - Input low selects standstill, high deselects.
// - Standstill acts only when its channel enabled.
// - Disabled standstill leaves inputs free for use.
// - Internal fault does not spread to group.
// - Selection acts per drive; channels may skew.
// - Restart: deselect, enable, 1/0 then 0/1 edge.
// - Four readable standstill status words.
// - Brake control on standstill or pulse cancellation.
// - Brake released only while drive current flows.
`timescale 1ns/1ps
`default_nettype none
module safe_standstill_interlock #(
  parameter int unsigned NUM_DRIVES = standstill_pkg::NUM_DRIVES,
  parameter int unsigned NUM_INPUTS = standstill_pkg::NUM_INPUTS,
  parameter int unsigned DISCREPANCY_CYCLES = standstill_pkg::DISCREPANCY_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_INPUTS-1:0] digital_input,
  input wire logic [NUM_DRIVES-1:0] pulse_enable_terminal,
  input wire logic [NUM_DRIVES-1:0] drive_enable,
  input wire logic [NUM_DRIVES-1:0] power_on_off_command,
  input wire logic [NUM_DRIVES-1:0] internal_fault,
  input wire logic [NUM_DRIVES-1:0] pulse_cancel_request,
  output logic [NUM_DRIVES-1:0] safe_standstill,
  output logic [NUM_DRIVES-1:0] safe_brake_control,
  output logic [NUM_DRIVES-1:0] brake_current_on,
  output logic [NUM_DRIVES-1:0] drive_powered,
  output logic [NUM_DRIVES-1:0] channel_fault
);
  initial begin
    if (NUM_DRIVES < 1 || NUM_DRIVES > 8 || NUM_INPUTS != standstill_pkg::NUM_INPUTS ||
        DISCREPANCY_CYCLES < 1) begin
      $error("safe_standstill_interlock: unsupported parameter values");
    end
  end

  logic extension_variant;
  logic [NUM_DRIVES-1:0] cu_standstill_enable;
  logic [NUM_DRIVES-1:0] pm_standstill_enable;
  logic [NUM_DRIVES*4-1:0] standstill_source_select;
  logic [NUM_DRIVES-1:0] cu_selected;
  logic [NUM_DRIVES-1:0] pm_selected;
  logic [NUM_DRIVES-1:0] onoff_prev;
  logic [NUM_DRIVES-1:0] restart_ok;
  standstill_pkg::restart_type restart_state [NUM_DRIVES];
  logic [31:0] disc_count [NUM_DRIVES];

  logic apb_access;
  logic apb_write;
  assign apb_access = psel && penable && pready;
  assign apb_write = apb_access && pwrite;

  // Picks the control-unit input for one drive; extension parts only see inputs 0 to 3.
  function automatic logic pick_input(input logic [3:0] sel, input logic ext,
                                      input logic [NUM_INPUTS-1:0] din);
    logic ok;
    ok = ext ? (sel < 4'(standstill_pkg::EXT_INPUTS)) : (sel < 4'(NUM_INPUTS));
    pick_input = ok ? din[sel[2:0]] : 1'b0;
  endfunction : pick_input

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = strb[b] ? wd[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction : merge

  // Byte-lane merges are formed outside the register process, because a part-select
  // cannot be taken directly of a function result.
  logic [31:0] cu_enable_merged;
  logic [31:0] pm_enable_merged;
  logic [31:0] source_merged;
  assign cu_enable_merged = merge(32'(cu_standstill_enable), pwdata, pstrb);
  assign pm_enable_merged = merge(32'(pm_standstill_enable), pwdata, pstrb);
  assign source_merged = merge(32'(standstill_source_select), pwdata, pstrb);

  // Configuration registers; one enable bit per drive per channel.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      extension_variant <= 1'b0;
      cu_standstill_enable <= '0;
      pm_standstill_enable <= '0;
      standstill_source_select <= '0;
    end else if (apb_write) begin
      case (paddr)
        standstill_pkg::CTRL_OFFSET: begin
          if (pstrb[0]) begin
            extension_variant <= pwdata[standstill_pkg::CTRL_EXTENSION_BIT];
          end
        end
        standstill_pkg::CU_ENABLE_OFFSET: begin
          cu_standstill_enable <= cu_enable_merged[NUM_DRIVES-1:0];
        end
        standstill_pkg::PM_ENABLE_OFFSET: begin
          pm_standstill_enable <= pm_enable_merged[NUM_DRIVES-1:0];
        end
        standstill_pkg::SOURCE_OFFSET: begin
          standstill_source_select <= source_merged[NUM_DRIVES*4-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Per-channel selection; a disabled channel ignores its terminal entirely.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cu_selected <= '0;
      pm_selected <= '0;
    end else begin
      for (int d = 0; d < NUM_DRIVES; d++) begin
        cu_selected[d] <= cu_standstill_enable[d] &&
          !pick_input(standstill_source_select[d*4 +: 4], extension_variant, digital_input);
        pm_selected[d] <= pm_standstill_enable[d] && !pulse_enable_terminal[d];
      end
    end
  end

  // Channels may skew; only a disagreement that outlasts the window is a fault.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_fault <= '0;
      for (int d = 0; d < NUM_DRIVES; d++) begin
        disc_count[d] <= '0;
      end
    end else begin
      for (int d = 0; d < NUM_DRIVES; d++) begin
        if (cu_standstill_enable[d] && pm_standstill_enable[d] &&
            (cu_selected[d] != pm_selected[d])) begin
          if (disc_count[d] >= 32'(DISCREPANCY_CYCLES - 1)) begin
            channel_fault[d] <= 1'b1;
          end else begin
            disc_count[d] <= disc_count[d] + 32'd1;
          end
        end else begin
          disc_count[d] <= '0;
        end
        if (apb_write && paddr == standstill_pkg::FAULT_CLEAR_OFFSET && pwdata[d] &&
            !(cu_selected[d] != pm_selected[d])) begin
          channel_fault[d] <= 1'b0;
        end
      end
    end
  end

  // Standstill per drive only; an internal fault never reaches group neighbours.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      safe_standstill <= '0;
      safe_brake_control <= '0;
    end else begin
      for (int d = 0; d < NUM_DRIVES; d++) begin
        safe_standstill[d] <= cu_selected[d] || pm_selected[d] ||
                              channel_fault[d] || internal_fault[d];
        safe_brake_control[d] <= cu_selected[d] || pm_selected[d] || channel_fault[d] ||
                                 internal_fault[d] || pulse_cancel_request[d];
      end
    end
  end

  // Restart sequence per drive.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      onoff_prev <= '0;
      drive_powered <= '0;
      restart_ok <= '0;
      for (int d = 0; d < NUM_DRIVES; d++) begin
        restart_state[d] <= standstill_pkg::restart_inhibit;
      end
    end else begin
      onoff_prev <= power_on_off_command;
      for (int d = 0; d < NUM_DRIVES; d++) begin
        restart_ok[d] <= !safe_standstill[d] && drive_enable[d];
        if (safe_brake_control[d] || !drive_enable[d]) begin
          restart_state[d] <= standstill_pkg::restart_inhibit;
          drive_powered[d] <= 1'b0;
        end else begin
          case (restart_state[d])
            standstill_pkg::restart_inhibit: begin
              if (restart_ok[d] && onoff_prev[d] && !power_on_off_command[d]) begin
                restart_state[d] <= standstill_pkg::restart_armed;
              end
            end
            standstill_pkg::restart_armed: begin
              if (!onoff_prev[d] && power_on_off_command[d]) begin
                restart_state[d] <= standstill_pkg::restart_running;
                drive_powered[d] <= 1'b1;
              end
            end
            standstill_pkg::restart_running: begin
              if (!power_on_off_command[d]) begin
                restart_state[d] <= standstill_pkg::restart_inhibit;
                drive_powered[d] <= 1'b0;
              end
            end
            default: begin
              restart_state[d] <= standstill_pkg::restart_inhibit;
            end
          endcase
        end
      end
    end
  end

  // Quiescent-current brake: drive current flows only when brake control is idle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brake_current_on <= '0;
    end else begin
      brake_current_on <= ~safe_brake_control & drive_powered;
    end
  end

  // APB slave answers in the access cycle; unmapped offsets answer with an error.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= '0;
        case (paddr)
          standstill_pkg::CTRL_OFFSET: prdata <= {31'h0, extension_variant};
          standstill_pkg::CU_ENABLE_OFFSET: prdata <= 32'(cu_standstill_enable);
          standstill_pkg::PM_ENABLE_OFFSET: prdata <= 32'(pm_standstill_enable);
          standstill_pkg::SOURCE_OFFSET: prdata <= 32'(standstill_source_select);
          standstill_pkg::FAULT_CLEAR_OFFSET: prdata <= 32'(channel_fault);
          standstill_pkg::CU_STATUS_OFFSET: prdata <= 32'(cu_selected);
          standstill_pkg::PM_STATUS_OFFSET: prdata <= 32'(pm_selected);
          standstill_pkg::COMBINED_STATUS_OFFSET: begin
            prdata <= {16'h0, 8'(channel_fault), 8'(safe_standstill)};
          end
          standstill_pkg::GROUP_STATUS_OFFSET: begin
            prdata <= {16'h0, 8'(safe_brake_control), 8'(cu_selected & pm_selected)};
          end
          standstill_pkg::RESTART_STATUS_OFFSET: prdata <= 32'(drive_powered);
          default: pslverr <= 1'b0;
        endcase
        if (!(paddr inside {standstill_pkg::CTRL_OFFSET, standstill_pkg::CU_ENABLE_OFFSET,
              standstill_pkg::PM_ENABLE_OFFSET, standstill_pkg::SOURCE_OFFSET,
              standstill_pkg::FAULT_CLEAR_OFFSET, standstill_pkg::CU_STATUS_OFFSET,
              standstill_pkg::PM_STATUS_OFFSET, standstill_pkg::COMBINED_STATUS_OFFSET,
              standstill_pkg::GROUP_STATUS_OFFSET, standstill_pkg::RESTART_STATUS_OFFSET})) begin
          pslverr <= 1'b1;
        end
      end
      if (pready) begin
        pready <= 1'b0;
      end
    end
  end

  // Checks watch drive 0, plus drive 1 in group_isolated_a; every drive is built from the same loop body, so one
  // lane is enough to catch a broken expression without multiplying the properties.
  // Each output is registered once, so a level input shows one edge later.
  brake_on_cancel_a: assert property (@(posedge pclk) disable iff (!presetn)
    pulse_cancel_request[0] |=> safe_brake_control[0])
    else $error("brake not started");

  brake_on_select_a: assert property (@(posedge pclk) disable iff (!presetn)
    safe_standstill[0] |-> safe_brake_control[0])
    else $error("standstill without brake control");

  brake_current_safe_a: assert property (@(posedge pclk) disable iff (!presetn)
    safe_brake_control[0] |=> !brake_current_on[0])
    else $error("brake current while braking");

  pm_select_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pm_standstill_enable[0] && !pulse_enable_terminal[0]) |=> pm_selected[0])
    else $error("low terminal did not select");

  cu_select_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cu_standstill_enable[0] && !extension_variant && !standstill_source_select[3] &&
     !digital_input[standstill_source_select[2:0]]) |=> cu_selected[0])
    else $error("low input did not select");

  ext_range_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cu_standstill_enable[0] && extension_variant &&
     standstill_source_select[3:0] >= 4'(standstill_pkg::EXT_INPUTS)) |=> cu_selected[0])
    else $error("out of range source not safe");

  disabled_free_a: assert property (@(posedge pclk) disable iff (!presetn)
    !cu_standstill_enable[0] |=> !cu_selected[0])
    else $error("disabled channel selected");

  pm_disabled_free_a: assert property (@(posedge pclk) disable iff (!presetn)
    !pm_standstill_enable[0] |=> !pm_selected[0])
    else $error("disabled terminal selected");

  arm_needs_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
    (restart_state[0] == standstill_pkg::restart_inhibit) ##1
    (restart_state[0] == standstill_pkg::restart_armed) |->
    $past(onoff_prev[0]) && !$past(power_on_off_command[0]))
    else $error("armed without falling edge");

  power_needs_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(drive_powered[0]) |-> $past(restart_state[0] == standstill_pkg::restart_armed))
    else $error("powered without armed restart");

  standstill_stops_a: assert property (@(posedge pclk) disable iff (!presetn)
    safe_standstill[0] |=> !drive_powered[0])
    else $error("powered during standstill");

  fault_local_a: assert property (@(posedge pclk) disable iff (!presetn)
    internal_fault[0] |=> safe_standstill[0])
    else $error("fault not honoured");

  group_isolated_a: assert property (@(posedge pclk) disable iff (!presetn)
    (internal_fault[0] && !internal_fault[1] && !cu_selected[1] && !pm_selected[1] &&
     !channel_fault[1]) |=> !safe_standstill[1])
    else $error("fault spread to group");

  apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready)
    else $error("slave late");

  skew_tolerated_a: assert property (@(posedge pclk) disable iff (!presetn)
    (disc_count[0] < 32'(DISCREPANCY_CYCLES - 1) && !channel_fault[0]) |=> !channel_fault[0])
    else $error("fault without discrepancy");

  fault_after_window_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cu_standstill_enable[0] && pm_standstill_enable[0] && (cu_selected[0] != pm_selected[0]) &&
     disc_count[0] >= 32'(DISCREPANCY_CYCLES - 1)) |=> channel_fault[0])
    else $error("discrepancy not reported");
endmodule : safe_standstill_interlock
`default_nettype wire

// [rtl/standstill_pkg.sv]
// Package with register map, field positions and reset values of the standstill interlock.
package standstill_pkg;
  localparam int unsigned NUM_DRIVES = 4;
  localparam int unsigned NUM_INPUTS = 8;
  localparam int unsigned EXT_INPUTS = 4;
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] CU_ENABLE_OFFSET = 8'h04;
  localparam logic [7:0] PM_ENABLE_OFFSET = 8'h08;
  localparam logic [7:0] SOURCE_OFFSET = 8'h0C;
  localparam logic [7:0] FAULT_CLEAR_OFFSET = 8'h10;
  localparam logic [7:0] CU_STATUS_OFFSET = 8'h20;
  localparam logic [7:0] PM_STATUS_OFFSET = 8'h24;
  localparam logic [7:0] COMBINED_STATUS_OFFSET = 8'h28;
  localparam logic [7:0] GROUP_STATUS_OFFSET = 8'h2C;
  localparam logic [7:0] RESTART_STATUS_OFFSET = 8'h30;
  localparam int unsigned CTRL_EXTENSION_BIT = 0;
  localparam int unsigned SOURCE_FIELD_WIDTH = 4;
  localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
  localparam logic [31:0] SOURCE_RESET = 32'h0000_0000;
  localparam int unsigned DISCREPANCY_MS = 500;
  localparam int unsigned CLOCK_MHZ = 100;
  localparam int unsigned DISCREPANCY_CYCLES = DISCREPANCY_MS * 1000 * CLOCK_MHZ;
  typedef enum logic [1:0] {
    restart_inhibit,
    restart_armed,
    restart_running
  } restart_type;
endpackage : standstill_pkg

// [verification/safety_controller_model.sv]
// Behavioural external safety controller that drives both standstill channels.
`timescale 1ns/1ps
`default_nettype none
module safety_controller_model (
  input wire logic clk,
  input wire logic [3:0] stop_req,
  input wire logic [3:0] cu_drop,
  output logic [7:0] digital_input,
  output logic [3:0] pulse_enable_terminal
);
  // Low requests standstill, so a dead output forces the safe state.
  // Inputs 4 to 7 idle high to deselect standstill.
  assign digital_input = {4'hF, ~(stop_req | cu_drop)};
  // The power-module channel trails by a cycle, which the interlock must tolerate.
  always_ff @(posedge clk) begin
    pulse_enable_terminal <= ~stop_req;
  end
endmodule : safety_controller_model
`default_nettype wire

// [verification/tb.sv]
// Self-checking testbench for the safe standstill interlock.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, digital_input;
  logic [31:0] pwdata, prdata, rd_data;
  logic [3:0] pstrb, stop_req, cu_drop, drive_enable, power_on_off_command, internal_fault;
  logic [3:0] pulse_cancel_request, safe_standstill, safe_brake_control, brake_current_on;
  logic [3:0] drive_powered, channel_fault, pulse_enable_terminal;
  int fails = 0;
  int cmp_count = 0;
  int cycles = 0;

  safety_controller_model safety_controller_model_inst (.clk(pclk), .stop_req(stop_req),
    .cu_drop(cu_drop), .digital_input(digital_input),
    .pulse_enable_terminal(pulse_enable_terminal));
  safe_standstill_interlock #(.DISCREPANCY_CYCLES(8)) safe_standstill_interlock_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .digital_input(digital_input),
    .pulse_enable_terminal(pulse_enable_terminal), .drive_enable(drive_enable),
    .power_on_off_command(power_on_off_command), .internal_fault(internal_fault),
    .pulse_cancel_request(pulse_cancel_request), .safe_standstill(safe_standstill),
    .safe_brake_control(safe_brake_control), .brake_current_on(brake_current_on),
    .drive_powered(drive_powered), .channel_fault(channel_fault));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  // The whole sequence needs well under a thousand cycles.
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      complete_run();
    end
  end

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // One APB transfer; the answer is taken at the rising edge where pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    err = pslverr;
    rd_data = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rd(input string name, input logic [7:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0000_0000);
    check(name, exp, rd_data);
  endtask : rd

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, err, rd_data} = '0;
    pstrb = 4'hF;
    {stop_req, cu_drop, drive_enable, power_on_off_command} = '0;
    {internal_fault, pulse_cancel_request} = '0;
    tick(12);
    presetn <= 1'b1;
    tick(1);
    rd("cu_enable", standstill_pkg::CU_ENABLE_OFFSET, standstill_pkg::ENABLE_RESET);
    rd("pm_enable", standstill_pkg::PM_ENABLE_OFFSET, standstill_pkg::ENABLE_RESET);
    rd("source", standstill_pkg::SOURCE_OFFSET, standstill_pkg::SOURCE_RESET);
    apb(1'b1, 8'h40, 32'h0000_0001);
    check("unmapped_err", 32'h1, {31'h0, err});
    stop_req <= 4'hF;
    tick(6);
    check("standstill_disabled", 32'h0, {28'h0, safe_standstill});
    stop_req <= 4'h0;
    apb(1'b1, standstill_pkg::CU_ENABLE_OFFSET, 32'h0000_000F);
    apb(1'b1, standstill_pkg::PM_ENABLE_OFFSET, 32'h0000_000F);
    apb(1'b1, standstill_pkg::SOURCE_OFFSET, 32'h0000_3210);
    tick(6);
    check("standstill_idle", 32'h0, {28'h0, safe_standstill});
    stop_req <= 4'b0010;
    tick(6);
    check("standstill_one", 32'h2, {28'h0, safe_standstill});
    check("brake_one", 32'h2, {28'h0, safe_brake_control});
    rd("combined", standstill_pkg::COMBINED_STATUS_OFFSET, 32'h0000_0002);
    $display("Test selection done");
    stop_req <= 4'h0;
    cu_drop <= 4'b0100;
    tick(20);
    check("fault_set", 32'h4, {28'h0, channel_fault});
    cu_drop <= 4'h0;
    tick(4);
    apb(1'b1, standstill_pkg::FAULT_CLEAR_OFFSET, 32'h0000_0004);
    tick(2);
    check("fault_clear", 32'h0, {28'h0, channel_fault});
    $display("Test discrepancy done");
    apb(1'b1, standstill_pkg::CTRL_OFFSET, 32'h0000_0001);
    apb(1'b1, standstill_pkg::SOURCE_OFFSET, 32'h0000_3215);
    tick(6);
    check("ext_range", 32'h1, {28'h0, safe_standstill});
    apb(1'b1, standstill_pkg::CTRL_OFFSET, 32'h0000_0000);
    // The long single-channel selection above may have latched a fault on drive 0.
    apb(1'b1, standstill_pkg::FAULT_CLEAR_OFFSET, 32'h0000_000F);
    tick(6);
    check("main_range", 32'h0, {28'h0, safe_standstill});
    $display("Test source range done");
    // Drives 0 and 1 form a group on one shared input.
    apb(1'b1, standstill_pkg::SOURCE_OFFSET, 32'h0000_3200);
    internal_fault <= 4'b0001;
    tick(6);
    check("group_mate", 32'h0, {31'h0, safe_standstill[1]});
    check("group_own", 32'h1, {31'h0, safe_standstill[0]});
    internal_fault <= 4'h0;
    pulse_cancel_request <= 4'b1000;
    tick(6);
    check("cancel_brake", 32'h1, {31'h0, safe_brake_control[3]});
    check("cancel_current", 32'h0, {31'h0, brake_current_on[3]});
    pulse_cancel_request <= 4'h0;
    apb(1'b1, standstill_pkg::FAULT_CLEAR_OFFSET, 32'h0000_000F);
    $display("Test group and brake done");
    drive_enable <= 4'hF;
    power_on_off_command <= 4'h1;
    tick(4);
    check("no_arm", 32'h0, {28'h0, drive_powered});
    power_on_off_command <= 4'h0;
    tick(3);
    power_on_off_command <= 4'h1;
    tick(4);
    check("powered", 32'h1, {31'h0, drive_powered[0]});
    check("released", 32'h1, {31'h0, brake_current_on[0]});
    stop_req <= 4'b0001;
    tick(6);
    check("stop_current", 32'h0, {31'h0, brake_current_on[0]});
    $display("Test restart done");
    complete_run();
  end
endmodule : tb
`default_nettype wire
